// ---- core/psp_ctrl.sv ----
// Pattern sequencing, gating sync pulse and precoder control
`timescale 1ns/100ps
module psp_ctrl #(
    parameter int LEN_W = 32
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    input  wire logic                      cfg_load,
    input  wire logic                      combine_en,
    input  wire psp_pkg::psp_ptype_t       pat_type,
    input  wire psp_pkg::psp_seq_t         seq_mode,
    input  wire logic [LEN_W-1:0]          first_data_channel_len,
    input  wire logic [15:0]               row_len,
    input  wire logic [15:0]               row_cnt,
    input  wire logic [7:0]                blk_cnt,
    input  wire logic [psp_pkg::PER_W-1:0] sync_width,
    input  wire logic [psp_pkg::PER_W-1:0] sync_delay,
    input  wire logic                      precode_en,
    input  wire logic                      precode_init,
    input  wire logic                      precode_init_val,
    input  wire logic                      pat_valid,
    input  wire logic                      pat_start,
    input  wire logic [1:0]                pat_data,
    input  wire logic                      burst_en,
    output logic                           out_valid,
    output logic [1:0]                     out_data,
    output logic                           gate_out,
    output logic                           cfg_busy,
    output logic                           cfg_err,
    output logic                           burst_active,
    output logic                           burst_refused,
    output logic [psp_pkg::PER_W-1:0]      period
);
    localparam int PW = psp_pkg::PER_W;

    // Period may reach length shifted by eight, so it must fit the counter
    if (LEN_W < 10 || LEN_W + 8 > PW) begin : g_len_chk
        $error("LEN_W out of range for period counter");
    end

    // Captured configuration
    logic                comb_q, comb_d;
    logic                mixed_q, mixed_d;
    logic                burst_q, burst_d;
    logic                refused_q, refused_d;
    logic [LEN_W-1:0]    len_q, len_d;
    logic [PW-1:0]       width_q, width_d;
    logic [PW-1:0]       delay_q, delay_d;
    logic [47:0]         prod_q, prod_d;
    // Range calculation
    psp_pkg::psp_calc_t  st_q, st_d;
    logic [PW-1:0]       acc_q, acc_d;
    logic [PW-1:0]       per_q, per_d;
    logic                err_q, err_d;
    // Pulse generation
    logic [PW-1:0]       pos_q, pos_d;
    logic                run_q, run_d;
    logic                seen_q, seen_d;
    logic                gate_q, gate_d;
    // Helpers
    logic                eligible, idle_load, cfg_ok, beat, in_win, bad;
    logic [PW-1:0]       gran, minlen, lim, cur_pos, inc;
    logic [PW:0]         nxt_pos, win_end;
    logic [3:0]          smask;

    // Shift that turns a length into its LCM with the granularity
    function automatic logic [3:0] lcm_shift(input logic [PW-1:0] v, input logic two);
        logic [3:0] tz, lg;
        logic       stop;
        tz   = 4'h0;
        stop = 1'h0;
        lg   = two ? psp_pkg::GRAN_LOG_2CH : psp_pkg::GRAN_LOG_1CH;
        for (int i = 0; i < 8; i++) begin
            if (!stop && !v[i]) begin
                tz = tz + 4'h1;
            end else begin
                stop = 1'h1;
            end
        end
        if (tz > lg) begin
            tz = lg;
        end
        return lg - tz;
    endfunction

    // Burst eligibility by pattern type
    always_comb begin
        case (pat_type)
            psp_pkg::PSP_PT_PRBS,
            psp_pkg::PSP_PT_ZERO_RUN,
            psp_pkg::PSP_PT_DATA,
            psp_pkg::PSP_PT_MIXED: eligible = 1'h1;
            default:               eligible = 1'h0;
        endcase
    end

    assign idle_load = cfg_load && (st_q == psp_pkg::CALC_IDLE);
    assign gran      = comb_q ? psp_pkg::GRAN_2CH : psp_pkg::GRAN_1CH;
    assign minlen    = comb_q ? psp_pkg::MIN_LEN_2CH : psp_pkg::MIN_LEN_1CH;
    assign smask     = comb_q ? psp_pkg::STEP_MASK_2CH : psp_pkg::STEP_MASK_1CH;

    // Configuration capture; a load during calculation is ignored
    always_comb begin
        comb_d    = comb_q;
        mixed_d   = mixed_q;
        burst_d   = burst_q;
        refused_d = refused_q;
        len_d     = len_q;
        width_d   = width_q;
        delay_d   = delay_q;
        prod_d    = prod_q;
        if (idle_load) begin
            comb_d    = combine_en;
            mixed_d   = (pat_type == psp_pkg::PSP_PT_MIXED);
            len_d     = first_data_channel_len;
            width_d   = sync_width;
            delay_d   = sync_delay;
            prod_d    = row_len * row_cnt * {8'h00, blk_cnt};
            burst_d   = (seq_mode == psp_pkg::PSP_SEQ_BURST) && eligible;
            refused_d = (seq_mode == psp_pkg::PSP_SEQ_BURST) && !eligible;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            comb_q    <= 1'h0;
            mixed_q   <= 1'h0;
            burst_q   <= 1'h0;
            refused_q <= 1'h0;
            len_q     <= '0;
            width_q   <= '0;
            delay_q   <= '0;
            prod_q    <= 48'h0;
        end else begin
            comb_q    <= comb_d;
            mixed_q   <= mixed_d;
            burst_q   <= burst_d;
            refused_q <= refused_d;
            len_q     <= len_d;
            width_q   <= width_d;
            delay_q   <= delay_d;
            prod_q    <= prod_d;
        end
    end

    // Range limit; mixed patterns carry an absolute cap
    always_comb begin
        lim = per_q - gran;
        if (mixed_q && lim > psp_pkg::MIXED_MAX) begin
            lim = psp_pkg::MIXED_MAX;
        end
        bad = (per_q < (gran << 1)) || (width_q < gran) || (width_q > lim) || ((width_q[3:0] & smask) != 4'h0);
        bad = bad || (delay_q < gran) || (delay_q > lim) || ((delay_q[3:0] & smask) != 4'h0);
    end

    // Period calculation: extend short pattern, then LCM by shifting
    always_comb begin
        st_d  = st_q;
        acc_d = acc_q;
        per_d = per_q;
        err_d = err_q;
        case (st_q)
            psp_pkg::CALC_IDLE: begin
                if (idle_load) begin
                    acc_d = '0;
                    st_d  = psp_pkg::CALC_EXT;
                end
            end
            psp_pkg::CALC_EXT: begin
                // mixed period is the block product
                if (mixed_q) begin
                    per_d = prod_q[PW-1:0];
                    st_d  = psp_pkg::CALC_CHECK;
                end else if (len_q == '0) begin
                    per_d = '0;
                    st_d  = psp_pkg::CALC_CHECK;
                end else if (acc_q >= minlen) begin
                    st_d = psp_pkg::CALC_LCM;
                end else begin
                    acc_d = acc_q + PW'(len_q);
                end
            end
            psp_pkg::CALC_LCM: begin
                per_d = acc_q << lcm_shift(acc_q, comb_q);
                st_d  = psp_pkg::CALC_CHECK;
            end
            psp_pkg::CALC_CHECK: begin
                err_d = bad;
                st_d  = psp_pkg::CALC_IDLE;
            end
            default: begin
                st_d = psp_pkg::CALC_IDLE;
            end
        endcase
    end

    // Error reads set until the first load is checked
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q  <= psp_pkg::CALC_IDLE;
            acc_q <= '0;
            per_q <= '0;
            err_q <= 1'h1;
        end else begin
            st_q  <= st_d;
            acc_q <= acc_d;
            per_q <= per_d;
            err_q <= err_d;
        end
    end

    // Stream gating: burst mode drops beats outside the burst window
    // burst gating of the stream
    assign beat   = pat_valid && (!burst_q || burst_en);
    assign cfg_ok = (st_q == psp_pkg::CALC_IDLE) && !err_q && !burst_q;

    // Window test; wrap past period end is handled as a second segment
    always_comb begin
        inc     = comb_q ? PW'(2) : PW'(1);
        cur_pos = (pat_start && !run_q) ? '0 : pos_q;
        nxt_pos = {1'b0, cur_pos} + {1'b0, inc};
        if (nxt_pos >= {1'b0, per_q}) begin
            nxt_pos = nxt_pos - {1'b0, per_q};
        end
        win_end = {1'b0, delay_q} + {1'b0, width_q};
        in_win  = ((cur_pos >= delay_q) && ({1'b0, cur_pos} < win_end))
               || ((win_end > {1'b0, per_q}) && ({1'b0, cur_pos} < (win_end - {1'b0, per_q})));
    end

    // Sync pulse generator, armed by the first pattern start
    always_comb begin
        pos_d  = pos_q;
        run_d  = run_q;
        seen_d = seen_q;
        gate_d = gate_q;
        if (!cfg_ok || idle_load) begin
            run_d  = 1'h0;
            seen_d = 1'h0;
            gate_d = 1'h0;
            pos_d  = '0;
        end else if (beat && (run_q || pat_start)) begin
            run_d  = 1'h1;
            pos_d  = nxt_pos[PW-1:0];
            seen_d = seen_q || (cur_pos >= delay_q);
            // rise only once delay is reached
            gate_d = in_win && (seen_q || cur_pos >= delay_q);
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pos_q  <= '0;
            run_q  <= 1'h0;
            seen_q <= 1'h0;
            gate_q <= 1'h0;
        end else begin
            pos_q  <= pos_d;
            run_q  <= run_d;
            seen_q <= seen_d;
            gate_q <= gate_d;
        end
    end

    psp_precoder u_precoder (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .active    (precode_en && comb_q),
        .init      (precode_init),
        .init_val  (precode_init_val),
        .in_valid  (beat),
        .in_data   (pat_data),
        .out_valid (out_valid),
        .out_data  (out_data)
    );

    assign gate_out      = gate_q;
    assign cfg_busy      = (st_q != psp_pkg::CALC_IDLE);
    assign cfg_err       = err_q;
    assign burst_active  = burst_q;
    assign burst_refused = refused_q;
    assign period        = per_q;
    property p_wrap;
        @(posedge clk_sys) disable iff (!rst_n)
        run_q && cfg_ok |-> pos_q < per_q;
    endproperty
    a_wrap: assert property (p_wrap) else $error("position ran past period");
    property p_rise;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(gate_out) |-> $past(cur_pos) == delay_q;
    endproperty
    a_rise: assert property (p_rise) else $error("pulse rose away from delay");
    property p_err_quiet;
        @(posedge clk_sys) disable iff (!rst_n)
        cfg_err || burst_active |=> !gate_out;
    endproperty
    a_err_quiet: assert property (p_err_quiet) else $error("gate active with bad setup");
    property p_step;
        @(posedge clk_sys) disable iff (!rst_n)
        !cfg_busy && !cfg_err && comb_q |-> width_q[3:0] == 4'h0 && delay_q[3:0] == 4'h0 && width_q >= 256;
    endproperty
    a_step: assert property (p_step) else $error("combined step accepted wrong");
    property p_refuse;
        @(posedge clk_sys) disable iff (!rst_n)
        idle_load && seq_mode == psp_pkg::PSP_SEQ_BURST && pat_type == psp_pkg::PSP_PT_OTHER
            |=> burst_refused && !burst_active;
    endproperty
    a_refuse: assert property (p_refuse) else $error("ineligible burst accepted");
    property p_burst_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        burst_active && !burst_en && pat_valid |=> !out_valid;
    endproperty
    a_burst_hold: assert property (p_burst_hold) else $error("data emitted outside burst");
    property p_repeat_flow;
        @(posedge clk_sys) disable iff (!rst_n)
        !burst_active && pat_valid |=> out_valid;
    endproperty
    a_repeat_flow: assert property (p_repeat_flow) else $error("repeat stream interrupted");
    property p_single_plain;
        @(posedge clk_sys) disable iff (!rst_n)
        !comb_q && pat_valid && !burst_active |=> out_data == $past(pat_data);
    endproperty
    a_single_plain: assert property (p_single_plain) else $error("precoder acted in single mode");
    property p_ext_len;
        @(posedge clk_sys) disable iff (!rst_n)
        st_q == psp_pkg::CALC_LCM |-> acc_q >= minlen && acc_q < minlen + PW'(len_q);
    endproperty
    a_ext_len: assert property (p_ext_len) else $error("short pattern extension wrong");
endmodule // psp_ctrl

// ---- core/psp_pkg.sv ----
// Constants and types shared by the pattern sync and precode control block
// Overview of operation
// - Precoder on/off; off passes data through
// - Precoder acts only in channel combining mode
// - One precoder setting serves all combined lanes
// - Two combined lanes use DQPSK precoding
// - Initialize loads precoder state, default one
// - Repeat mode emits pattern continuously
// - Burst mode emits pattern only in bursts
// - Burst only for PRBS, zero-run, data, mixed
// - Shared settings; length follows first data channel
// - Repeat gating pulse width, multiple of eight
// - Width range from LCM, 8/16 bit steps
// - Mixed width range from block product, capped
// - Pulse rises a programmed delay after start
// - Delay range from LCM, 8/16 bit steps
// - Mixed delay range from block product
// - Short patterns extended to 512/1024 bits
package psp_pkg;
    localparam int PER_W = 40;  // Period and position counter width

    localparam logic [PER_W-1:0] GRAN_1CH    = 40'h00_0000_0080;
    localparam logic [PER_W-1:0] GRAN_2CH    = 40'h00_0000_0100;
    localparam logic [PER_W-1:0] MIN_LEN_1CH = 40'h00_0000_0200;
    localparam logic [PER_W-1:0] MIN_LEN_2CH = 40'h00_0000_0400;
    localparam logic [PER_W-1:0] MIXED_MAX   = 40'h00_8fff_ff80;
    localparam logic [3:0]       GRAN_LOG_1CH = 4'h7;
    localparam logic [3:0]       GRAN_LOG_2CH = 4'h8;
    localparam logic [3:0]       STEP_MASK_1CH = 4'h7;
    localparam logic [3:0]       STEP_MASK_2CH = 4'hf;
    localparam logic             INIT_DEFAULT = 1'h1;

    typedef enum logic [2:0] {
        PSP_PT_PRBS,
        PSP_PT_ZERO_RUN,
        PSP_PT_DATA,
        PSP_PT_MIXED,
        PSP_PT_OTHER
    } psp_ptype_t;

    typedef enum logic {
        PSP_SEQ_REPEAT,
        PSP_SEQ_BURST
    } psp_seq_t;

    typedef enum logic [1:0] {
        CALC_IDLE,
        CALC_EXT,
        CALC_LCM,
        CALC_CHECK
    } psp_calc_t;
endpackage

// ---- core/psp_precoder.sv ----
// Two-lane differential quadrature precoder with pass-through
`timescale 1ns/100ps
module psp_precoder (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       active,
    input  wire logic       init,
    input  wire logic       init_val,
    input  wire logic       in_valid,
    input  wire logic [1:0] in_data,
    output logic            out_valid,
    output logic      [1:0] out_data
);
    logic [1:0] st_q, st_d;
    logic [1:0] dat_q, dat_d;
    logic       vld_q, vld_d;
    logic [1:0] enc;

    // Encoder: lane 0 is I, lane 1 is Q; odd state parity swaps lanes
    always_comb begin
        enc = (st_q[0] ^ st_q[1]) ? {in_data[0] ^ st_q[1], in_data[1] ^ st_q[0]}
                                  : {in_data[1] ^ st_q[1], in_data[0] ^ st_q[0]};
        st_d  = st_q;
        vld_d = in_valid;
        dat_d = in_valid ? in_data : dat_q;
        if (init) begin
            st_d = {init_val, init_val};
        end else if (in_valid && active) begin
            st_d = enc;
        end
        if (in_valid && active && !init) begin
            dat_d = enc;
        end
    end

    // State resets to the default seed so a forgotten initialize still works
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q  <= {2{psp_pkg::INIT_DEFAULT}};
            dat_q <= 2'h0;
            vld_q <= 1'h0;
        end else begin
            st_q  <= st_d;
            dat_q <= dat_d;
            vld_q <= vld_d;
        end
    end

    assign out_valid = vld_q;
    assign out_data  = dat_q;

    property p_bypass;
        @(posedge clk_sys) disable iff (!rst_n)
        in_valid && !active |=> out_valid && out_data == $past(in_data);
    endproperty
    a_bypass: assert property (p_bypass) else $error("precoder off but data altered");

    property p_seed;
        @(posedge clk_sys) disable iff (!rst_n)
        init |=> st_q == {2{$past(init_val)}};
    endproperty
    a_seed: assert property (p_seed) else $error("initialize did not seed state");

    property p_diff;
        @(posedge clk_sys) disable iff (!rst_n)
        in_valid && active && !init && !(st_q[0] ^ st_q[1])
            |=> (out_data ^ $past(st_q)) == $past(in_data) && st_q == out_data;
    endproperty
    a_diff: assert property (p_diff) else $error("differential encoding wrong");
endmodule // psp_precoder

// ---- test/psp_rx_model.sv ----
// Far-side receiver model: counts delivered beats and keeps the last symbol
`timescale 1ns/100ps
module psp_rx_model (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       rx_valid,
    input  wire logic [1:0] rx_data,
    output int              rx_count,
    output logic [1:0]      rx_last
);
    // A line receiver never pushes back, so every valid beat must be taken
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_count <= 0;
            rx_last  <= 2'h0;
        end else if (rx_valid) begin
            rx_count <= rx_count + 1;
            rx_last  <= rx_data;
        end
    end
endmodule // psp_rx_model

// ---- test/pattern_sync_precode_ctrl_bench.sv ----
// Self-checking bench for the pattern sync and precode control block
`timescale 1ns/100ps
module pattern_sync_precode_ctrl_bench;
    logic                clk_sys, rst_n, cfg_load, combine_en, precode_en, precode_init;
    logic                precode_init_val, pat_valid, pat_start, burst_en;
    logic                out_valid, gate_out, cfg_busy, cfg_err, burst_active, burst_refused;
    psp_pkg::psp_ptype_t pat_type;
    psp_pkg::psp_seq_t   seq_mode;
    logic [31:0]         len;
    logic [15:0]         row_len, row_cnt;
    logic [7:0]          blk_cnt;
    logic [39:0]         sync_width, sync_delay, period;
    logic [1:0]          pat_data, out_data, rx_last;
    int                  rx_count, miscompares, n_compared;

    psp_ctrl #(.LEN_W(32)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .cfg_load(cfg_load),
        .combine_en(combine_en), .pat_type(pat_type), .seq_mode(seq_mode),
        .first_data_channel_len(len), .row_len(row_len), .row_cnt(row_cnt), .blk_cnt(blk_cnt),
        .sync_width(sync_width), .sync_delay(sync_delay), .precode_en(precode_en),
        .precode_init(precode_init), .precode_init_val(precode_init_val), .pat_valid(pat_valid),
        .pat_start(pat_start), .pat_data(pat_data), .burst_en(burst_en), .out_valid(out_valid),
        .out_data(out_data), .gate_out(gate_out), .cfg_busy(cfg_busy), .cfg_err(cfg_err),
        .burst_active(burst_active), .burst_refused(burst_refused), .period(period));

    psp_rx_model rx_u (.clk_sys(clk_sys), .rst_n(rst_n), .rx_valid(out_valid), .rx_data(out_data),
        .rx_count(rx_count), .rx_last(rx_last));

    // 40 MHz system clock
    initial begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic summarize();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Load a configuration and wait, bounded, for the range check to finish
    task automatic cfg(input logic comb, input psp_pkg::psp_ptype_t pt, input psp_pkg::psp_seq_t sq,
                       input logic [31:0] ln, input logic [39:0] w, input logic [39:0] d);
        int i;
        combine_en = comb;
        pat_type = pt;
        seq_mode = sq;
        len = ln;
        sync_width = w;
        sync_delay = d;
        cfg_load = 1'h1;
        @(negedge clk_sys);
        cfg_load = 1'h0;
        chk(cfg_busy, 1'h1, "busy after load"); // settings captured
        for (i = 0; i < 2000 && cfg_busy !== 1'h0; i++) @(negedge clk_sys);
        if (i == 2000) begin
            miscompares++;
            summarize();
        end
    endtask

    // Drive one beat; valid is left up so back-to-back beats never re-raise it, caller lowers it
    task automatic beat(input logic v, input logic s, input logic [1:0] d);
        pat_valid = v;
        pat_start = s;
        pat_data = d;
        @(negedge clk_sys);
    endtask

    // Short pattern is stretched, pulse repeats every period at fixed offset
    task automatic t_gate(input logic comb);
        int bpb, per, w, d, p;
        bpb = comb ? 2 : 1;
        per = comb ? 1024 : 512;
        w = comb ? 272 : 136;
        d = comb ? 256 : 128;
        cfg(comb, psp_pkg::PSP_PT_PRBS, psp_pkg::PSP_SEQ_REPEAT, 32'h0000_0080, w, d);
        chk(period, per, "effective period"); // stretched length
        chk(cfg_err, 1'h0, "good config"); // in range
        for (int k = 0; k < 2 * per / bpb; k++) begin
            p = (k * bpb) % per;
            // Second start mid-period must not re-align the pulse
            beat(1'h1, k == 0 || k == 37, k[1:0]);
            chk(out_valid, 1'h1, "repeat beat out"); // continuous
            chk(gate_out, p >= d && p < d + w, "gate level"); // pulse
        end
        pat_valid = 1'h0;
    endtask

    task automatic erow(input logic comb, input logic [31:0] ln, input logic [39:0] w,
                        input logic [39:0] d, input logic e);
        cfg(comb, psp_pkg::PSP_PT_PRBS, psp_pkg::PSP_SEQ_REPEAT, ln, w, d);
        chk(cfg_err, e, "range check"); // range
        chk(gate_out, 1'h0, "gate idle"); // no pulse yet
    endtask

    // bounds and steps of width, bounds of delay
    task automatic t_err();
        erow(0, 128, 132, 128, 1);
        erow(0, 128, 0, 128, 1);
        erow(0, 128, 128, 120, 1);
        erow(0, 128, 384, 384, 0);
        erow(0, 128, 392, 128, 1);
        erow(0, 0, 136, 128, 1);
        erow(1, 128, 264, 256, 1);
        erow(1, 128, 768, 768, 0);
        erow(1, 128, 256, 240, 1);
        // mixed period is the block product
        cfg(0, psp_pkg::PSP_PT_MIXED, psp_pkg::PSP_SEQ_REPEAT, 128, 384, 384);
        chk(period, 40'h00_0000_0200, "mixed period"); // product
        chk(cfg_err, 1'h0, "mixed at limit"); // limit
        cfg(0, psp_pkg::PSP_PT_MIXED, psp_pkg::PSP_SEQ_REPEAT, 128, 392, 128);
        chk(cfg_err, 1'h1, "mixed over limit"); // limit
    endtask

    function automatic logic [1:0] enc(input logic [1:0] s, input logic [1:0] d);
        if (s[0] ^ s[1]) return {d[0] ^ s[1], d[1] ^ s[0]};
        return {d[1] ^ s[1], d[0] ^ s[0]};
    endfunction

    task automatic t_pre(input logic comb, input logic en, input logic iv);
        logic [1:0] s, e;
        cfg(comb, psp_pkg::PSP_PT_PRBS, psp_pkg::PSP_SEQ_REPEAT, 128, 272, 256);
        precode_en = en;
        precode_init_val = iv;
        precode_init = 1'h1;
        @(negedge clk_sys);
        precode_init = 1'h0;
        s = {iv, iv};
        for (int k = 0; k < 8; k++) begin
            beat(1'h1, 1'h0, k[1:0] ^ k[2]);
            e = (comb && en) ? enc(s, k[1:0] ^ k[2]) : k[1:0] ^ k[2];
            chk(out_data, e, "lane data"); // coding
            s = e;
        end
        pat_valid = 1'h0;
        @(negedge clk_sys);
        chk(rx_last, e, "far side symbol"); // delivered
    endtask

    // burst eligibility and gating of the stream
    task automatic t_burst();
        int c;
        for (int t = 0; t < 5; t++) begin
            cfg(0, psp_pkg::psp_ptype_t'(t), psp_pkg::PSP_SEQ_BURST, 128, 136, 128);
            chk(burst_active, t < 4, "burst taken"); // eligible
            chk(burst_refused, t == 4, "burst refused"); // other
        end
        cfg(0, psp_pkg::PSP_PT_PRBS, psp_pkg::PSP_SEQ_BURST, 128, 136, 128);
        c = rx_count;
        beat(1'h1, 1'h1, 2'h1);
        chk(out_valid, 1'h0, "closed window"); // gap
        burst_en = 1'h1;
        beat(1'h1, 1'h0, 2'h2);
        chk(out_valid, 1'h1, "open window"); // burst
        burst_en = 1'h0;
        pat_valid = 1'h0;
        @(negedge clk_sys);
        chk(rx_count, c + 1, "one beat delivered"); // one beat
        chk(gate_out, 1'h0, "gate silent in burst"); // shared gate
    endtask

    initial begin
        {cfg_load, combine_en, precode_en, precode_init, pat_valid, pat_start, burst_en} = 7'h00;
        precode_init_val = psp_pkg::INIT_DEFAULT;
        pat_type = psp_pkg::PSP_PT_PRBS;
        seq_mode = psp_pkg::PSP_SEQ_REPEAT;
        {len, sync_width, sync_delay} = 112'h0;
        {row_len, row_cnt, blk_cnt} = 40'h0008_0008_08;
        pat_data = 2'h0;
        miscompares = 0;
        n_compared = 0;
        rst_n = 1'h0;
        repeat (3) @(negedge clk_sys);
        chk(cfg_err, 1'h1, "reset error flag"); // gate held off
        chk(period, 40'h0, "reset period"); // no period yet
        chk({gate_out, out_valid}, 2'h0, "reset gate and valid"); // idle outputs
        rst_n = 1'h1;
        t_gate(0);
        t_gate(1);
        t_err();
        t_pre(1, 1, 1);
        t_pre(1, 1, 0);
        t_pre(1, 0, 1);
        t_pre(0, 1, 1);
        t_burst();
        summarize();
    end
endmodule // pattern_sync_precode_ctrl_bench
